// ===== sbtc_count_source.sv
/*
 sbtc_count_source: far side of the timer: count pin source and crystal.
 assumes: clk is the bench clock; crystal period is 20 clk, scaled down.
*/
`default_nettype none
module sbtc_count_source (
   input wire logic clk,
   input wire logic osc_en,
   output logic ext_in,
   output logic xtal_out
);
   timeunit 1ns;
   timeprecision 1ns;
   logic [3:0] ph = 4'h0;
   initial ext_in = 1'b0;
   initial xtal_out = 1'b0;
   // crystal stands still while powered down
   always @(posedge clk) begin
      if (!osc_en) begin
         ph <= 4'h0;
         xtal_out <= 1'b0;
      end else if (ph == 4'h9) begin
         ph <= 4'h0;
         xtal_out <= !xtal_out;
      end else begin
         ph <= ph + 4'h1;
      end
   end
   // rising edges on the count pin, idle low between them
   task automatic edges(input int n);
      repeat (n) begin
         repeat (6) @(posedge clk);
         ext_in <= 1'b1;
         repeat (6) @(posedge clk);
         ext_in <= 1'b0;
      end
   endtask
endmodule
`default_nettype wire

// ===== sbtc_pkg.sv
/*
 sbtc_pkg: register map, field positions, reset values and timing for the
 sixteen-bit timer/counter.
 assumes: used by the timer top and its bound checker, every use written sbtc_pkg::name.
*/
`default_nettype none

package sbtc_pkg;

   // ----------------------------------------------------------------
   // register byte addresses (one aligned word each)
   // ----------------------------------------------------------------
   localparam logic [3:0] ADDR_CONTROL = 4'h0;
   localparam logic [3:0] ADDR_COUNT_LOW = 4'h4;
   localparam logic [3:0] ADDR_COUNT_HIGH = 4'h8;
   localparam logic [3:0] ADDR_IRQ_STATUS = 4'hC;
   // mask shares the status word, guarded by its own write bit
   localparam logic [3:0] ADDR_IRQ_MASK = 4'hC;

   // ----------------------------------------------------------------
   // control register fields
   // ----------------------------------------------------------------
   localparam int BIT_COUNT_RUN = 0;
   localparam int BIT_SOURCE_EXT = 1;
   localparam int BIT_SYNC_BYPASS = 2;
   localparam int BIT_CRYSTAL_ON = 3;
   localparam int BIT_DIVIDE_LO = 4;
   localparam int BIT_DIVIDE_HI = 5;
   localparam int BIT_SYSCLK_XTAL = 6;
   localparam int BIT_WIDE_ACCESS = 7;
   localparam logic [7:0] CONTROL_RESET = 8'h00;
   localparam logic [7:0] CONTROL_WRITE_MASK = 8'hBF;

   // ----------------------------------------------------------------
   // interrupt bits and counts
   // ----------------------------------------------------------------
   localparam int IRQ_BIT_OVERFLOW = 0;
   localparam int BIT_MASK_GUARD = 31;
   localparam int MASK_LSB = 8;
   localparam logic [15:0] COUNT_RESET = 16'h0000;
   localparam logic [15:0] COUNT_MAX = 16'hFFFF;
   localparam logic [2:0] DIVIDE_RESET = 3'h0;
   localparam int INSTR_CLK_DIV = 4;

   typedef enum logic [1:0] {
      SBTC_DIV1,
      SBTC_DIV2,
      SBTC_DIV4,
      SBTC_DIV8
   } sbtc_divide_type;

endpackage

`default_nettype wire

// ===== sbtc_timer.sv
/*
 sbtc_timer: sixteen-bit up counter with internal or external clock source,
 optional input synchroniser, 1:1..1:8 divider, buffered 16-bit access,
 overflow interrupt and compare-trigger reset, on an Avalon-MM slave.
 assumes: clk is the system clock (10 MHz); the external count input and the
 crystal output arrive asynchronously; the oscillator itself is analog and
 outside, this block only drives its enable.
*/
`default_nettype none

// ----------------------------------------------------------------
// Overview of operation
// - counts only while count_run is set
// - internal source increments every fourth system clock
// - external source counts rising input or crystal edges
// - sync_bypass chooses synchronised or raw external edges
// - internal source ignores sync_bypass entirely
// - two-bit field divides input by 1,2,4,8
// - crystal_osc_on enables the crystal, else powered down
// - read-only bit shows system clock from crystal
// - wide_access_mode selects sixteen-bit or byte access
// - low byte read latches live high byte
// - high write buffers; low write commits both bytes
// - wide mode never touches live high directly
// - low byte write clears divider, high does not
// - enabled timer forces pins input, reads zero
// - crystal keeps running in every power mode
// - wraps FFFFh to 0000h, sets overflow flag
// - compare trigger clears count unless external with sync_bypass; software write wins
// ----------------------------------------------------------------
module sbtc_timer (
   input wire logic clk,
   input wire logic rst,
   input wire logic [3:0] avs_address,
   input wire logic avs_read,
   input wire logic avs_write,
   input wire logic [31:0] avs_writedata,
   input wire logic [3:0] avs_byteenable,
   output logic [31:0] avs_readdata,
   output logic avs_waitrequest,
   output logic avs_response_err,
   input wire logic external_count_input,
   input wire logic crystal_clock_in,
   input wire logic sysclk_from_crystal_in,
   input wire logic compare_event_trigger,
   input wire logic power_managed_mode,
   input wire logic [1:0] pin_direction_bits,
   input wire logic [1:0] pin_level_in,
   output logic [1:0] pin_output_enable,
   output logic [1:0] pin_read_value,
   output logic crystal_osc_enable,
   output logic irq
);

   logic [7:0] control_q;
   logic [15:0] count_q;
   logic [7:0] high_buffer_q;
   logic [2:0] divide_q;
   logic [1:0] phase_q;
   logic [7:0] irq_status_q;
   logic [7:0] irq_mask_q;
   logic ack_q;
   logic [31:0] readdata_q;
   logic err_q;

   logic ext_sync1_q;
   logic ext_sync2_q;
   logic ext_sync3_q;
   logic raw_meta_q;
   logic raw_prev_q;
   logic xtal_sync1_q;
   logic xtal_sync2_q;
   logic run_sync1_q;
   logic run_sync2_q;

   // ----------------------------------------------------------------
   // decode helpers
   // ----------------------------------------------------------------
   function automatic logic hit(input logic [3:0] addr, input logic [3:0] target);
      hit = (addr == target);
   endfunction

   function automatic logic [2:0] divide_last(input logic [1:0] sel);
      case (sbtc_pkg::sbtc_divide_type'(sel))
         sbtc_pkg::SBTC_DIV1: divide_last = 3'h0;
         sbtc_pkg::SBTC_DIV2: divide_last = 3'h1;
         sbtc_pkg::SBTC_DIV4: divide_last = 3'h3;
         sbtc_pkg::SBTC_DIV8: divide_last = 3'h7;
         default: divide_last = 3'h0;
      endcase
   endfunction

   logic count_run;
   logic source_select_external;
   logic sync_bypass;
   logic crystal_osc_on;
   logic [1:0] input_divide_select;
   logic wide_access_mode;

   assign count_run = control_q[sbtc_pkg::BIT_COUNT_RUN];
   assign source_select_external = control_q[sbtc_pkg::BIT_SOURCE_EXT];
   assign sync_bypass = control_q[sbtc_pkg::BIT_SYNC_BYPASS];
   assign crystal_osc_on = control_q[sbtc_pkg::BIT_CRYSTAL_ON];
   assign input_divide_select = control_q[sbtc_pkg::BIT_DIVIDE_HI:sbtc_pkg::BIT_DIVIDE_LO];
   assign wide_access_mode = control_q[sbtc_pkg::BIT_WIDE_ACCESS];

   // ----------------------------------------------------------------
   // bus strobes
   // ----------------------------------------------------------------
   // one wait state: request taken when ack_q is low, answered next cycle
   // writes and the low-byte read side effect land at the taking edge;
   // the answer cycle only hands back what was registered there
   logic req;
   logic wr_go;
   logic rd_go;
   assign req = (avs_read | avs_write) & ~ack_q;
   assign wr_go = avs_write & ~ack_q & avs_byteenable[0];
   assign rd_go = avs_read & ~ack_q;
   assign avs_waitrequest = (avs_read | avs_write) & ~ack_q;
   assign avs_readdata = readdata_q;
   assign avs_response_err = err_q;

   logic wr_ctrl;
   logic wr_low;
   logic wr_high;
   logic wr_stat;
   logic wr_mask;
   logic rd_low;
   assign wr_ctrl = wr_go & hit(avs_address, sbtc_pkg::ADDR_CONTROL);
   assign wr_low = wr_go & hit(avs_address, sbtc_pkg::ADDR_COUNT_LOW);
   assign wr_high = wr_go & hit(avs_address, sbtc_pkg::ADDR_COUNT_HIGH);
   assign wr_stat = wr_go & hit(avs_address, sbtc_pkg::ADDR_IRQ_STATUS);
   assign wr_mask = wr_go & hit(avs_address, sbtc_pkg::ADDR_IRQ_MASK)
      & avs_writedata[sbtc_pkg::BIT_MASK_GUARD];
   assign rd_low = rd_go & hit(avs_address, sbtc_pkg::ADDR_COUNT_LOW);

   // ----------------------------------------------------------------
   // external clock paths
   // ----------------------------------------------------------------
   // crystal output when enabled, else the count pin
   logic ext_source;
   assign ext_source = crystal_osc_on ? crystal_clock_in : external_count_input;

   // synchronised path: two flops, edge seen between 2nd and 3rd
   always_ff @(posedge clk) begin
      if (rst) begin
         ext_sync1_q <= 1'b0;
         ext_sync2_q <= 1'b0;
         ext_sync3_q <= 1'b0;
      end else begin
         ext_sync1_q <= ext_source;
         ext_sync2_q <= ext_sync1_q;
         ext_sync3_q <= ext_sync2_q;
      end
   end

   // bypass path: single sample, lower latency but may miss or
   // misplace edges near clk; only one domain exists here so this is
   // the closest model of an unsynchronised counter
   always_ff @(posedge clk) begin
      if (rst) begin
         raw_meta_q <= 1'b0;
         raw_prev_q <= 1'b0;
      end else begin
         raw_meta_q <= ext_source;
         raw_prev_q <= raw_meta_q;
      end
   end

   always_ff @(posedge clk) begin
      if (rst) begin
         xtal_sync1_q <= 1'b0;
         xtal_sync2_q <= 1'b0;
         run_sync1_q <= 1'b0;
         run_sync2_q <= 1'b0;
      end else begin
         xtal_sync1_q <= sysclk_from_crystal_in;
         xtal_sync2_q <= xtal_sync1_q;
         run_sync1_q <= power_managed_mode;
         run_sync2_q <= run_sync1_q;
      end
   end

   // ----------------------------------------------------------------
   // tick selection
   // ----------------------------------------------------------------
   logic internal_tick;
   logic ext_tick_sync;
   logic ext_tick_raw;
   logic source_tick;
   // phase runs even while stopped, so the first tick after start comes
   // within four cycles rather than exactly four
   assign internal_tick = (phase_q == 2'(sbtc_pkg::INSTR_CLK_DIV - 1));
   assign ext_tick_sync = ext_sync2_q & ~ext_sync3_q;
   assign ext_tick_raw = raw_meta_q & ~raw_prev_q;

   always_comb begin
      if (!source_select_external) begin
         source_tick = internal_tick;
      end else if (sync_bypass) begin
         source_tick = ext_tick_raw;
      end else begin
         source_tick = ext_tick_sync;
      end
   end

   always_ff @(posedge clk) begin
      if (rst) begin
         phase_q <= 2'h0;
      end else begin
         phase_q <= phase_q + 2'h1;
      end
   end

   // ----------------------------------------------------------------
   // divider and counter
   // ----------------------------------------------------------------
   // a divide change mid-count may let the divider run once through its
   // three-bit wrap before it lines up with the new ratio
   logic div_tick;
   assign div_tick = count_run & source_tick & (divide_q == divide_last(input_divide_select));

   always_ff @(posedge clk) begin
      if (rst) begin
         divide_q <= sbtc_pkg::DIVIDE_RESET;
      end else if (wr_low) begin
         divide_q <= sbtc_pkg::DIVIDE_RESET;
      end else if (count_run & source_tick) begin
         if (div_tick) begin
            divide_q <= sbtc_pkg::DIVIDE_RESET;
         end else begin
            divide_q <= divide_q + 3'h1;
         end
      end
   end

   // compare trigger ignored when counting unsynchronised: the raw edge
   // and the trigger are not ordered, so a clear could tear the count
   logic trigger_ok;
   assign trigger_ok = compare_event_trigger & ~(source_select_external & sync_bypass);

   always_ff @(posedge clk) begin
      if (rst) begin
         count_q <= sbtc_pkg::COUNT_RESET;
      end else if (wr_low) begin
         // writes win over the trigger
         if (wide_access_mode) begin
            count_q <= {high_buffer_q, avs_writedata[7:0]};
         end else begin
            count_q[7:0] <= avs_writedata[7:0];
         end
      end else if (wr_high & ~wide_access_mode) begin
         // byte mode only; in wide mode this address reaches the buffer
         count_q[15:8] <= avs_writedata[7:0];
      end else if (trigger_ok) begin
         count_q <= sbtc_pkg::COUNT_RESET;
      end else if (div_tick) begin
         count_q <= count_q + 16'h0001;
      end
   end

   // ----------------------------------------------------------------
   // high byte buffer
   // ----------------------------------------------------------------
   always_ff @(posedge clk) begin
      if (rst) begin
         high_buffer_q <= 8'h00;
      end else if (wide_access_mode & wr_high) begin
         high_buffer_q <= avs_writedata[7:0];
      end else if (wide_access_mode & rd_low) begin
         high_buffer_q <= count_q[15:8];
      end
   end

   // ----------------------------------------------------------------
   // control and interrupt registers
   // ----------------------------------------------------------------
   always_ff @(posedge clk) begin
      if (rst) begin
         control_q <= sbtc_pkg::CONTROL_RESET;
      end else if (wr_ctrl) begin
         control_q <= avs_writedata[7:0] & sbtc_pkg::CONTROL_WRITE_MASK;
      end
   end

   // a wrap lost to a write or trigger never happened, so no flag
   logic overflow_event;
   assign overflow_event = div_tick & (count_q == sbtc_pkg::COUNT_MAX) & ~wr_low
      & ~(wr_high & ~wide_access_mode) & ~trigger_ok;

   always_ff @(posedge clk) begin
      if (rst) begin
         irq_status_q <= 8'h00;
      end else begin
         // set wins over a write-one clear
         irq_status_q[sbtc_pkg::IRQ_BIT_OVERFLOW] <= overflow_event
            | (irq_status_q[sbtc_pkg::IRQ_BIT_OVERFLOW]
            & ~(wr_stat & avs_writedata[sbtc_pkg::IRQ_BIT_OVERFLOW]));
         irq_status_q[7:1] <= 7'h00;
      end
   end

   // ----------------------------------------------------------------
   // interrupt mask
   // ----------------------------------------------------------------
   // guard bit keeps a plain write-one clear of the status byte from
   // wiping the mask as a side effect
   always_ff @(posedge clk) begin
      if (rst) begin
         irq_mask_q <= 8'h00;
      end else if (wr_mask) begin
         irq_mask_q <= {7'h00,
            avs_writedata[sbtc_pkg::IRQ_BIT_OVERFLOW + sbtc_pkg::MASK_LSB]};
      end
   end

   assign irq = |(irq_status_q & irq_mask_q);

   // ----------------------------------------------------------------
   // read path
   // ----------------------------------------------------------------
   // read data registered at the taking edge, stands until the next read
   logic [7:0] control_view;
   always_comb begin
      control_view = control_q;
      control_view[sbtc_pkg::BIT_SYSCLK_XTAL] = xtal_sync2_q;
   end

   always_ff @(posedge clk) begin
      if (rst) begin
         ack_q <= 1'b0;
         readdata_q <= 32'h00000000;
         err_q <= 1'b0;
      end else begin
         ack_q <= req;
         err_q <= 1'b0;
         if (rd_go) begin
            case (avs_address)
               sbtc_pkg::ADDR_CONTROL: readdata_q <= {24'h000000, control_view};
               sbtc_pkg::ADDR_COUNT_LOW: readdata_q <= {24'h000000, count_q[7:0]};
               sbtc_pkg::ADDR_COUNT_HIGH: begin
                  if (wide_access_mode) begin
                     readdata_q <= {24'h000000, high_buffer_q};
                  end else begin
                     readdata_q <= {24'h000000, count_q[15:8]};
                  end
               end
               sbtc_pkg::ADDR_IRQ_STATUS: readdata_q <= {16'h0000, irq_mask_q, irq_status_q};
               default: begin
                  readdata_q <= 32'h00000000;
                  err_q <= 1'b1;
               end
            endcase
         end else if (req) begin
            err_q <= ~(avs_address[1:0] == 2'h0);
         end
      end
   end

   // ----------------------------------------------------------------
   // pins and oscillator
   // ----------------------------------------------------------------
   // pins never driven while timer enabled; direction bits ignored
   assign pin_output_enable = count_run ? 2'h0 : ~pin_direction_bits;
   assign pin_read_value = count_run ? 2'h0 : pin_level_in;

   // enable follows the bit alone, whatever the power mode
   // software must allow start-up time before relying on it
   assign crystal_osc_enable = crystal_osc_on | (crystal_osc_on & run_sync2_q);

endmodule

`default_nettype wire

// ===== sbtc_timer_properties.sv
/*
 sbtc_timer_properties: port-level checker for the timer, bound to sbtc_timer.
 assumes: single clock domain, the master holds each request until answered.
*/
`default_nettype none
module sbtc_timer_properties (
   input wire logic clk,
   input wire logic rst,
   input wire logic [3:0] avs_address,
   input wire logic avs_read,
   input wire logic avs_write,
   input wire logic [31:0] avs_writedata,
   input wire logic [3:0] avs_byteenable,
   input wire logic [31:0] avs_readdata,
   input wire logic avs_waitrequest,
   input wire logic avs_response_err,
   input wire logic sysclk_from_crystal_in,
   input wire logic power_managed_mode,
   input wire logic [1:0] pin_direction_bits,
   input wire logic [1:0] pin_output_enable,
   input wire logic [1:0] pin_read_value,
   input wire logic crystal_osc_enable,
   input wire logic irq
);
   default clocking @(posedge clk); endclocking
   default disable iff (rst);
   // ----------------------------------------------------------------
   // shadow of control and mask, built only from writes at the taking edge
   // ----------------------------------------------------------------
   logic [7:0] ctrl_q;
   logic mask_q;
   logic wr_take;
   logic rd_done;
   logic s;
   // the design applies a write at the edge where waitrequest is still high
   assign wr_take = avs_write && avs_waitrequest;
   assign rd_done = avs_read && !avs_waitrequest;
   assign s = sysclk_from_crystal_in;
   always_ff @(posedge clk) begin
      if (rst) begin
         ctrl_q <= 8'h00;
         mask_q <= 1'b0;
      end else begin
         if (wr_take && avs_byteenable[0] && avs_address == sbtc_pkg::ADDR_CONTROL)
            ctrl_q <= avs_writedata[7:0];
         if (wr_take && avs_byteenable[0] && avs_address == sbtc_pkg::ADDR_IRQ_MASK
            && avs_writedata[sbtc_pkg::BIT_MASK_GUARD])
            mask_q <= avs_writedata[sbtc_pkg::MASK_LSB];
      end
   end
   wait_first_a: assert property ((avs_read || avs_write) && !$past(avs_read || avs_write)
      |-> avs_waitrequest) else $error("no wait state on a new request");
   wait_one_a: assert property ((avs_read || avs_write) && avs_waitrequest
      |=> !avs_waitrequest) else $error("request not answered after one wait state");
   unmapped_read_a: assert property (rd_done && avs_address[1:0] != 2'b00
      |-> avs_response_err && avs_readdata == 32'h0) else $error("unmapped read answer wrong");
   ctrl_readback_a: assert property (rd_done && avs_address == sbtc_pkg::ADDR_CONTROL
      |-> (avs_readdata[7:0] & sbtc_pkg::CONTROL_WRITE_MASK) == (ctrl_q & 8'hBF))
      else $error("control readback differs from written value");
   sysclk_status_a: assert property (rd_done && avs_address == sbtc_pkg::ADDR_CONTROL
      && $past(s) == s && $past(s, 2) == s && $past(s, 3) == s && $past(s, 4) == s
      |-> avs_readdata[6] == s) else $error("clock status bit wrong");
   osc_follow_a: assert property (crystal_osc_enable == ctrl_q[3])
      else $error("crystal enable does not follow control bit 3");
   osc_steady_a: assert property ($changed(power_managed_mode) && !wr_take
      |=> $stable(crystal_osc_enable)) else $error("crystal enable moved with power mode");
   pins_run_a: assert property (ctrl_q[0]
      |-> pin_output_enable == 2'b00 && pin_read_value == 2'b00)
      else $error("pins not forced to input while running");
   pins_idle_a: assert property (!ctrl_q[0] |-> pin_output_enable == ~pin_direction_bits)
      else $error("pin enables wrong while stopped");
   irq_mask_a: assert property (!mask_q |-> !irq)
      else $error("interrupt high while masked");
endmodule
bind sbtc_timer sbtc_timer_properties chk_u (.clk, .rst, .avs_address, .avs_read, .avs_write,
   .avs_writedata, .avs_byteenable, .avs_readdata, .avs_waitrequest, .avs_response_err,
   .sysclk_from_crystal_in, .power_managed_mode, .pin_direction_bits, .pin_output_enable,
   .pin_read_value, .crystal_osc_enable, .irq);
`default_nettype wire

// ===== sbtc_timer_tb.sv
/*
 sbtc_timer_tb: self-checking bench for sbtc_timer with its count source.
 assumes: checker attached by bind; one wait state per bus access.
*/
`default_nettype none
module sbtc_timer_tb;
   timeunit 1ns;
   timeprecision 1ns;
   logic clk = 1'b0, rst = 1'b1, avs_read = 1'b0, avs_write = 1'b0, sys_in = 1'b0;
   logic trig = 1'b0, pm = 1'b0, wreq, err, ext_in, xtal, osc_en, irq;
   logic [3:0] avs_address = 4'h0;
   logic [31:0] avs_writedata = 32'h0, rdata, q;
   logic [1:0] dir = 2'b11, lvl = 2'b00, poe, prd;
   int n_errors = 0, compares = 0;
   always #50 clk = ~clk;
   sbtc_timer dut_u (.clk(clk), .rst(rst), .avs_address(avs_address), .avs_read(avs_read),
      .avs_write(avs_write), .avs_writedata(avs_writedata), .avs_byteenable(4'hF),
      .avs_readdata(rdata), .avs_waitrequest(wreq), .avs_response_err(err),
      .external_count_input(ext_in), .crystal_clock_in(xtal), .sysclk_from_crystal_in(sys_in),
      .compare_event_trigger(trig), .power_managed_mode(pm), .pin_direction_bits(dir),
      .pin_level_in(lvl), .pin_output_enable(poe), .pin_read_value(prd),
      .crystal_osc_enable(osc_en), .irq(irq));
   sbtc_count_source src_u (.clk(clk), .osc_en(osc_en), .ext_in(ext_in), .xtal_out(xtal));
   // ----------------------------------------------------------------
   // shared tasks
   // ----------------------------------------------------------------
   task automatic chk(input string n, input logic [31:0] e, input logic [31:0] g);
      compares++;
      if (g !== e) begin
         n_errors++;
         $display("ERROR %s expected %h seen %h", n, e, g);
      end
   endtask
   task automatic bus(input logic w, input logic [3:0] a, input logic [31:0] d);
      @(posedge clk);
      avs_read <= !w;
      avs_write <= w;
      avs_address <= a;
      avs_writedata <= d;
      do @(posedge clk); while (wreq !== 1'b0);
      q = rdata;
      avs_read <= 1'b0;
      avs_write <= 1'b0;
   endtask
   task automatic wr(input logic [3:0] a, input logic [31:0] d);
      bus(1'b1, a, d);
   endtask
   task automatic rd(input logic [3:0] a);
      bus(1'b0, a, 32'h0);
   endtask
   task automatic tally_and_finish;
      $display("n_errors %0d compares %0d", n_errors, compares);
      if (n_errors == 0 && compares > 0)
         $display("STATUS OK");
      else
         $display("STATUS NOT OK");
      $finish;
   endtask
   // ----------------------------------------------------------------
   // scenarios
   // ----------------------------------------------------------------
   task automatic t_reset;
      rd(4'h0);
      chk("ctrl_reset", 32'h0, q[7:0]);
      wr(4'h0, 32'hFF);
      wr(4'h0, 32'h0);
      sys_in <= 1'b1;
      repeat (4) @(posedge clk);
      rd(4'h0);
      chk("ctrl_status", 32'h40, q[7:0]);
      sys_in <= 1'b0;
      wr(4'h6, 32'hFF);
      rd(4'h6);
      chk("unmapped", 32'h0, q);
   endtask
   task automatic t_internal;
      logic [7:0] c0;
      for (int d = 0; d < 4; d++) begin
         wr(4'h0, 32'h0);
         wr(4'h4, 32'h0);
         wr(4'h0, 32'h01 | (d << 4) | ((d & 1) << 2));
         rd(4'h4);
         c0 = q[7:0];
         repeat ((20 << d) - 3) @(posedge clk);
         rd(4'h4);
         chk("ticks", 32'd5, q[7:0] - c0);
      end
      wr(4'h0, 32'h0);
      rd(4'h4);
      c0 = q[7:0];
      repeat (40) @(posedge clk);
      rd(4'h4);
      chk("held", c0, q[7:0]);
   endtask
   task automatic t_external;
      wr(4'h4, 32'h0);
      wr(4'h0, 32'h13);
      src_u.edges(6);
      repeat (8) @(posedge clk);
      rd(4'h4);
      chk("sync_div2", 32'd3, q[7:0]);
      src_u.edges(1);
      wr(4'h8, 32'h0);
      src_u.edges(1);
      repeat (8) @(posedge clk);
      rd(4'h4);
      chk("high_keeps_div", 32'd4, q[7:0]);
      wr(4'h0, 32'h07);
      wr(4'h4, 32'h0);
      src_u.edges(5);
      repeat (8) @(posedge clk);
      rd(4'h4);
      chk("raw_edges", 32'd5, q[7:0]);
   endtask
   task automatic t_crystal;
      logic [7:0] c0;
      wr(4'h0, 32'h0B);
      chk("osc_on", 32'h1, osc_en);
      pm <= 1'b1;
      repeat (60) @(posedge clk);
      chk("osc_in_pm", 32'h1, osc_en);
      rd(4'h4);
      c0 = q[7:0];
      repeat (97) @(posedge clk);
      rd(4'h4);
      chk("xtal_ticks", 32'd5, q[7:0] - c0);
      pm <= 1'b0;
      wr(4'h0, 32'h0);
      chk("osc_off", 32'h0, osc_en);
   endtask
   task automatic t_wide;
      int i;
      wr(4'h0, 32'h80);
      wr(4'h8, 32'hAB);
      wr(4'h4, 32'hFF);
      wr(4'h8, 32'h55);
      wr(4'h0, 32'h0);
      rd(4'h8);
      chk("live_high", 32'hAB, q[7:0]);
      wr(4'h0, 32'h80);
      rd(4'h4);
      rd(4'h8);
      chk("buffered_high", 32'hAB, q[7:0]);
      wr(4'h8, 32'hFF);
      wr(4'h4, 32'hFF);
      wr(4'hC, 32'h8000_0100);
      wr(4'h0, 32'h81);
      for (i = 0; i < 40 && irq !== 1'b1; i++) @(posedge clk);
      wr(4'h0, 32'h80);
      rd(4'h4);
      rd(4'h8);
      chk("wrapped_high", 32'h0, q[7:0]);
      rd(4'hC);
      chk("status_mask", 32'h101, q[8:0]);
      wr(4'hC, 32'h8000_0000);
      @(negedge clk);
      chk("irq_masked", 32'h0, irq);
      wr(4'hC, 32'h8000_0100);
      @(negedge clk);
      chk("irq_raised", 32'h1, irq);
      wr(4'hC, 32'h1);
      @(negedge clk);
      chk("irq_cleared", 32'h0, irq);
   endtask
   task automatic t_trig_pins;
      wr(4'h0, 32'h0);
      wr(4'h4, 32'h40);
      @(posedge clk) trig <= 1'b1;
      @(posedge clk) trig <= 1'b0;
      rd(4'h4);
      chk("trigger_clear", 32'h0, q[7:0]);
      fork
         wr(4'h4, 32'h21);
         begin
            @(posedge clk) trig <= 1'b1;
            @(posedge clk) trig <= 1'b0;
         end
      join
      rd(4'h4);
      chk("write_beats_trigger", 32'h21, q[7:0]);
      dir <= 2'b01;
      lvl <= 2'b11;
      wr(4'h0, 32'h1);
      @(negedge clk);
      chk("pins_run", 32'h0, {poe, prd});
      wr(4'h0, 32'h0);
      @(negedge clk);
      chk("pins_stop", 32'hB, {poe, prd});
   endtask
   initial begin
      repeat (4) @(posedge clk);
      rst <= 1'b0;
      t_reset();
      t_internal();
      t_external();
      t_crystal();
      t_wide();
      t_trig_pins();
      tally_and_finish();
   end
   initial begin
      repeat (20000) @(posedge clk);
      n_errors++;
      tally_and_finish();
   end
endmodule
`default_nettype wire
